// ---- core/hostif_defs.vh ----
`ifndef HOSTIF_DEFS_VH
`define HOSTIF_DEFS_VH

// Clock rate and the quiet time the host keeps after reset.
`define CLK_MHZ 100
`define RESET_WAIT_US 100
`define RESET_WAIT_CYC (`RESET_WAIT_US * `CLK_MHZ)

// Register and memory shapes.
`define DATA_W 8
`define ADDR_W 7
`define GLYPH_ADDR_W 6
`define DISP_DEPTH 128
`define GLYPH_DEPTH 64
`define FIFO_DEPTH 8

// Field positions.
`define BUSY_BIT 7
`define INSTR_DISP_BIT 7
`define INSTR_GLYPH_BIT 6
`define SER_HDR_RS 1
`define SER_HDR_RD 0

// Serial frame: header byte then data byte, first bit is the msb.
`define SER_HDR_LAST 5'h07
`define SER_FRAME_LAST 5'h0f
`define SER_FRAME_DONE 5'h10

`endif

// ---- core/vfd_host_interface.v ----
`timescale 1ns/1ps
`default_nettype none
`include "hostif_defs.vh"

////////////////////////////////////////////////////////////////////////////////

module write_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = `FIFO_DEPTH
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam PW = $clog2(DEPTH);
  localparam [PW:0] FULL = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PW-1:0] wr_q;
  reg [PW-1:0] rd_q;
  reg [PW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != {(PW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= {PW{1'b0}};
      rd_q <= {PW{1'b0}};
      cnt_q <= {(PW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH - 1) ? {PW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH - 1) ? {PW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // write_fifo

////////////////////////////////////////////////////////////////////////////////

// Function
// RULE1: Link select pin low picks serial link, high picks parallel bus.
// RULE2: Parallel bus carries whole bytes or two nibbles on the upper lines.
// RULE3: Host ties unused pins; the device ignores pins of the unused link.
// RULE4: Two host-visible eight-bit registers: instruction and RAM data.
// RULE5: Instruction register cannot be read back by the host.
// RULE6: A data register write is committed to display or glyph RAM.
// RULE7: Address instruction fetches the addressed RAM byte into data register.
// RULE8: Each data register read fetches the next address for the next read.
// RULE9: Register select low targets instruction/status, high targets data.
// RULE10: Select low write loads instruction register, per bus style strobes.
// RULE11: Select low read returns busy flag on bit 7, address counter below.
// RULE12: Select high write loads data register and commits it to RAM.
// RULE13: Select high read returns the prefetched data register contents.
// RULE14: Host waits 100 microseconds after reset before any access.
// RULE15: Busy flag always reads zero.
// RULE16: Address counter steps by one after each data access, either direction.
// RULE17: Bus style pin picks enable plus read/write, or separate strobes.
// RULE18: Serial frame under low strobe, bits on rising shift clock, eight per byte.
// RULE19: Parallel access window is chip select low overlapping the strobe.
module vfd_host_interface #(
  parameter RESET_WAIT_CYC = `RESET_WAIT_CYC,
  parameter DISP_DEPTH = `DISP_DEPTH,
  parameter GLYPH_DEPTH = `GLYPH_DEPTH,
  parameter FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire ref_clk,
  input wire rst,
  input wire link_select_pin,
  input wire bus_style_select,
  input wire data_width_8,
  input wire addr_decrement,
  input wire cs_n,
  input wire register_select,
  input wire e_rd,
  input wire rw_wr,
  input wire [7:0] parallel_data_lines_in,
  output reg [7:0] parallel_data_lines_out_q,
  output reg parallel_data_lines_oe_q,
  input wire serial_frame_strobe_n,
  input wire sck,
  input wire si,
  output reg so_q,
  input wire ram_hold,
  input wire [`ADDR_W-1:0] scan_disp_addr,
  output reg [7:0] scan_disp_data_q,
  input wire [`GLYPH_ADDR_W-1:0] scan_glyph_addr,
  output reg [7:0] scan_glyph_data_q,
  output reg [7:0] instr_code_q,
  output reg instr_strobe_q,
  output reg host_ready_q
);
  localparam WAIT_W = $clog2(RESET_WAIT_CYC + 1);
  localparam [WAIT_W-1:0] WAIT_END = RESET_WAIT_CYC;
  localparam FW = 1 + `ADDR_W + `DATA_W;

  function [7:0] read_byte;
    input rs;
    input [7:0] dr;
    input [6:0] ac;
    begin
      read_byte = rs ? dr : {1'b0, ac}; // RULE5 RULE15
    end
  endfunction

  reg [7:0] disp_mem [0:DISP_DEPTH-1], glyph_mem [0:GLYPH_DEPTH-1];
  reg [WAIT_W-1:0] wait_q;
  reg go_q, glyph_sel_q, fetch_q, pwin_q, prs_q, prd_q, nib_lo_q, sck_q;
  reg [7:0] dr_q, pdat_q, hdr_q, sdat_q, shout_q;
  reg [`ADDR_W-1:0] ac_q;
  reg [3:0] nib_hi_q;
  reg [4:0] bit_q;
  wire par_mode, pwin, pread, p_end, par_ev, sfr, srise, ser_ev, ev, ev_rs, ev_rd;
  wire fifo_in_ready, fifo_out_valid, drain, dr_write;
  wire [7:0] par_byte, rbyte, ev_data, sbyte;
  wire [FW-1:0] fifo_out;
  wire [`ADDR_W-1:0] ac_step;

  ////////////////////////////////////////////////////////////////////////////
  // Hold off all accesses until the post-reset quiet time is over.

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_q <= {WAIT_W{1'b0}};
      go_q <= 1'b0;
      host_ready_q <= 1'b0;
    end else begin
      if (!go_q) begin
        wait_q <= wait_q + 1'b1; // RULE14
      end
      if (wait_q == WAIT_END) begin
        go_q <= 1'b1; // RULE14
      end
      host_ready_q <= go_q && fifo_in_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel bus: the window is chip select low overlapping the strobe.

  assign par_mode = link_select_pin; // RULE1
  assign pwin = par_mode && go_q && !cs_n &&
                (bus_style_select ? e_rd : (!e_rd || !rw_wr)); // RULE17 RULE19
  assign pread = bus_style_select ? rw_wr : !e_rd; // RULE17
  assign p_end = pwin_q && !pwin;
  assign par_ev = p_end && (data_width_8 || nib_lo_q); // RULE2
  assign par_byte = data_width_8 ? pdat_q : {nib_hi_q, pdat_q[7:4]}; // RULE2
  assign rbyte = read_byte(register_select, dr_q, ac_q); // RULE9 RULE11 RULE13

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwin_q <= 1'b0;
      prs_q <= 1'b0;
      prd_q <= 1'b0;
      pdat_q <= 8'h00;
      nib_lo_q <= 1'b0;
      nib_hi_q <= 4'h0;
      parallel_data_lines_out_q <= 8'h00;
      parallel_data_lines_oe_q <= 1'b0;
    end else begin
      pwin_q <= pwin;
      if (pwin) begin
        prs_q <= register_select;
        prd_q <= pread;
        pdat_q <= parallel_data_lines_in;
      end
      if (!data_width_8) begin
        nib_lo_q <= nib_lo_q ^ p_end; // RULE2
      end else begin
        nib_lo_q <= 1'b0;
      end
      if (p_end && !nib_lo_q) begin
        nib_hi_q <= pdat_q[7:4];
      end
      parallel_data_lines_oe_q <= pwin && pread;
      if (data_width_8) begin
        parallel_data_lines_out_q <= rbyte;
      end else if (nib_lo_q) begin
        parallel_data_lines_out_q <= {rbyte[3:0], 4'h0}; // RULE2
      end else begin
        parallel_data_lines_out_q <= {rbyte[7:4], 4'h0}; // RULE2
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial link: header byte (select, read) then one data byte per frame.

  assign sfr = !par_mode && go_q && !cs_n && !serial_frame_strobe_n; // RULE1 RULE3
  assign srise = sfr && sck && !sck_q; // RULE18
  assign ser_ev = srise && (bit_q == `SER_FRAME_LAST); // RULE18
  assign sbyte = read_byte(hdr_q[`SER_HDR_RS-1], dr_q, ac_q); // RULE18

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sck_q <= 1'b0;
      bit_q <= 5'h00;
      hdr_q <= 8'h00;
      sdat_q <= 8'h00;
      shout_q <= 8'h00;
      so_q <= 1'b0;
    end else begin
      sck_q <= sck;
      if (!sfr) begin
        bit_q <= 5'h00;
      end else if (srise) begin
        if (bit_q != `SER_FRAME_DONE) begin
          bit_q <= bit_q + 5'h01;
        end
        if (bit_q <= `SER_HDR_LAST) begin
          hdr_q <= {hdr_q[6:0], si}; // RULE18
        end else begin
          sdat_q <= {sdat_q[6:0], si}; // RULE18
        end
        if (bit_q == `SER_HDR_LAST) begin
          shout_q <= sbyte; // RULE18
          so_q <= sbyte[7]; // RULE18
        end else if (bit_q < `SER_FRAME_LAST) begin
          shout_q <= {shout_q[6:0], 1'b0};
          so_q <= shout_q[6]; // RULE18
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Common byte event from whichever link is active.

  assign ev = par_ev || ser_ev;
  assign ev_rs = par_mode ? prs_q : hdr_q[`SER_HDR_RS]; // RULE9
  assign ev_rd = par_mode ? prd_q : hdr_q[`SER_HDR_RD];
  assign ev_data = par_mode ? par_byte : {sdat_q[6:0], si};
  assign dr_write = ev && ev_rs && !ev_rd;
  assign ac_step = addr_decrement ? ac_q - 1'b1 : ac_q + 1'b1; // RULE16
  assign drain = fifo_out_valid && !ram_hold;

  write_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_write_fifo (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(dr_write),
    .in_ready(fifo_in_ready),
    .in_data({glyph_sel_q, ac_q, ev_data}),
    .out_valid(fifo_out_valid),
    .out_ready(!ram_hold),
    .out_data(fifo_out)
  );

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      instr_code_q <= 8'h00;
      instr_strobe_q <= 1'b0;
      dr_q <= 8'h00;
      ac_q <= {`ADDR_W{1'b0}};
      glyph_sel_q <= 1'b0;
      fetch_q <= 1'b0;
    end else begin
      instr_strobe_q <= 1'b0;
      if (fetch_q && !fifo_out_valid) begin
        fetch_q <= 1'b0;
        if (glyph_sel_q) begin
          dr_q <= glyph_mem[ac_q[`GLYPH_ADDR_W-1:0]]; // RULE7 RULE8
        end else begin
          dr_q <= disp_mem[ac_q]; // RULE7 RULE8
        end
      end
      if (ev && !ev_rs && !ev_rd) begin
        instr_code_q <= ev_data; // RULE4 RULE10
        instr_strobe_q <= 1'b1; // RULE10
        if (ev_data[`INSTR_DISP_BIT]) begin
          glyph_sel_q <= 1'b0;
          ac_q <= ev_data[`ADDR_W-1:0];
          fetch_q <= 1'b1; // RULE7
        end else if (ev_data[`INSTR_GLYPH_BIT]) begin
          glyph_sel_q <= 1'b1;
          ac_q <= {1'b0, ev_data[`GLYPH_ADDR_W-1:0]};
          fetch_q <= 1'b1; // RULE7
        end
      end else if (dr_write && fifo_in_ready) begin
        dr_q <= ev_data; // RULE4 RULE12
        ac_q <= ac_step; // RULE16
        fetch_q <= 1'b0;
      end else if (ev && ev_rs && ev_rd) begin
        ac_q <= ac_step; // RULE16
        fetch_q <= 1'b1; // RULE8
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RAM commit from the write queue and the scan read ports.

  always @(posedge ref_clk) begin
    if (drain) begin
      if (fifo_out[FW-1]) begin
        glyph_mem[fifo_out[`DATA_W +: `GLYPH_ADDR_W]] <= fifo_out[`DATA_W-1:0]; // RULE6 RULE12
      end else begin
        disp_mem[fifo_out[`DATA_W +: `ADDR_W]] <= fifo_out[`DATA_W-1:0]; // RULE6 RULE12
      end
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scan_disp_data_q <= 8'h00;
      scan_glyph_data_q <= 8'h00;
    end else begin
      scan_disp_data_q <= disp_mem[scan_disp_addr];
      scan_glyph_data_q <= glyph_mem[scan_glyph_addr];
    end
  end
endmodule // vfd_host_interface

`default_nettype wire

// ---- bench/hostif_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// Watches the parallel host port from the outside.
module hostif_checker #(parameter RESET_WAIT_CYC = 20) (
  input wire ref_clk,
  input wire rst,
  input wire link_select_pin,
  input wire bus_style_select,
  input wire data_width_8,
  input wire cs_n,
  input wire register_select,
  input wire e_rd,
  input wire rw_wr,
  input wire [7:0] parallel_data_lines_out_q,
  input wire parallel_data_lines_oe_q,
  input wire instr_strobe_q,
  input wire host_ready_q
);
  wire win = !cs_n && link_select_pin && (bus_style_select ? e_rd : (!e_rd || !rw_wr));
  wire rd = bus_style_select ? rw_wr : !e_rd;
  logic [15:0] cnt_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      cnt_q <= 16'h0000;
    else if (cnt_q != 16'hffff)
      cnt_q <= cnt_q + 16'h0001;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence rd_held;
    host_ready_q && win && rd ##1 win;
  endsequence
  sequence status_held;
    host_ready_q && win && rd && !register_select && data_width_8 ##1 win && !register_select;
  endsequence
  chk_read_drive: assert property (rd_held |-> parallel_data_lines_oe_q)
    else $error("read window without bus drive");
  chk_bus_release: assert property ((!win || !rd) |=> !parallel_data_lines_oe_q)
    else $error("bus driven outside a read window");
  chk_serial_quiet: assert property (!link_select_pin |=> !parallel_data_lines_oe_q)
    else $error("parallel bus driven in serial mode");
  chk_busy_zero: assert property (status_held |-> !parallel_data_lines_out_q[7])
    else $error("busy flag read as one");
  chk_nibble_low: assert property (parallel_data_lines_oe_q && !data_width_8 |-> parallel_data_lines_out_q[3:0] == 4'h0)
    else $error("low lines not zero in nibble mode");
  chk_strobe_pulse: assert property (instr_strobe_q |=> !instr_strobe_q)
    else $error("instruction strobe longer than one cycle");
  chk_strobe_cause: assert property (instr_strobe_q && link_select_pin |-> $past(win, 2) && !$past(win) && !$past(register_select, 2) && !$past(rd, 2))
    else $error("instruction strobe without instruction write");
  chk_reset_wait: assert property (host_ready_q |-> int'(cnt_q) > RESET_WAIT_CYC)
    else $error("ready before reset wait");
endmodule // hostif_checker
`default_nettype wire

// ---- bench/host_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side: parallel bus cycles and serial frames.
module host_bus_model (
  input wire ref_clk,
  input wire bus_style_select,
  input wire [7:0] rdata,
  input wire so,
  output logic cs_n,
  output logic register_select,
  output logic e_rd,
  output logic rw_wr,
  output logic [7:0] wdata,
  output logic serial_frame_strobe_n,
  output logic sck,
  output logic si
);
  logic act = 1'b0;
  logic rdr = 1'b1;
  logic ser = 1'b0;
  assign cs_n = !(act || ser);
  assign e_rd = bus_style_select ? act : !(act && rdr);
  assign rw_wr = bus_style_select ? rdr : !(act && !rdr);
  initial begin
    register_select = 1'b0;
    wdata = 8'h00;
    serial_frame_strobe_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic xfer(input logic rs, input logic rd, input logic [7:0] wd, output logic [7:0] rv);
    @(posedge ref_clk) #1;
    register_select = rs;
    rdr = rd;
    wdata = wd;
    act = 1'b1;
    repeat (3) @(posedge ref_clk);
    rv = rdata;
    #1 act = 1'b0;
    wdata = ~wd;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic frame(input logic [15:0] v, output logic [7:0] rv);
    @(posedge ref_clk) #1;
    ser = 1'b1;
    serial_frame_strobe_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      si = v[i];
      repeat (2) @(posedge ref_clk);
      #1 rv[i % 8] = so;
      sck = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 sck = 1'b0;
    end
    repeat (2) @(posedge ref_clk);
    #1 serial_frame_strobe_n = 1'b1;
    ser = 1'b0;
  endtask
endmodule // host_bus_model
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic link_select_pin = 1'b1;
  logic bus_style_select = 1'b1;
  logic data_width_8 = 1'b1;
  logic addr_decrement = 1'b0;
  logic ram_hold = 1'b0;
  logic [6:0] scan_disp_addr = 7'h00;
  logic [5:0] scan_glyph_addr = 6'h00;
  wire cs_n, register_select, e_rd, rw_wr, serial_frame_strobe_n, sck, si, so_q, oe_q, instr_strobe_q, host_ready_q;
  wire [7:0] din, dout, scan_disp_data_q, scan_glyph_data_q, instr_code_q;
  int failures = 0;
  int cmp_count = 0;
  logic [7:0] rv;
  // Rows hold select, read, byte driven and byte expected.
  logic [17:0] rows [0:9] = '{18'h08000, 18'h24100, 18'h24200, 18'h10002, 18'h08000,
    18'h30041, 18'h30042, 18'h10002, 18'h04000, 18'h21f00};
  always #5 ref_clk = ~ref_clk;
  vfd_host_interface #(.RESET_WAIT_CYC(20)) u_vfd_host_interface (.ref_clk(ref_clk), .rst(rst),
    .link_select_pin(link_select_pin), .bus_style_select(bus_style_select), .data_width_8(data_width_8),
    .addr_decrement(addr_decrement), .cs_n(cs_n), .register_select(register_select), .e_rd(e_rd),
    .rw_wr(rw_wr), .parallel_data_lines_in(din), .parallel_data_lines_out_q(dout),
    .parallel_data_lines_oe_q(oe_q), .serial_frame_strobe_n(serial_frame_strobe_n), .sck(sck), .si(si),
    .so_q(so_q), .ram_hold(ram_hold), .scan_disp_addr(scan_disp_addr), .scan_disp_data_q(scan_disp_data_q),
    .scan_glyph_addr(scan_glyph_addr), .scan_glyph_data_q(scan_glyph_data_q), .instr_code_q(instr_code_q),
    .instr_strobe_q(instr_strobe_q), .host_ready_q(host_ready_q));
  host_bus_model u_host_bus_model (.ref_clk(ref_clk), .bus_style_select(bus_style_select), .rdata(dout),
    .cs_n(cs_n), .register_select(register_select), .e_rd(e_rd), .rw_wr(rw_wr), .wdata(din),
    .serial_frame_strobe_n(serial_frame_strobe_n), .sck(sck), .si(si), .so(so_q));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (host_ready_q !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 200) begin
      failures++;
      complete_run();
    end
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 rst = 1'b0;
    check({7'h00, host_ready_q}, 8'h00);
    wait_ready();
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 10; r++) begin
        u_host_bus_model.xfer(rows[r][17], rows[r][16], rows[r][15:8], rv);
        if (rows[r][16])
          check(rv, rows[r][7:0]);
        else if (!rows[r][17])
          check(instr_code_q, rows[r][15:8]);
      end
      #1 bus_style_select = 1'b0;
    end
    check(scan_disp_data_q, 8'h41);
    check(scan_glyph_data_q, 8'h1f);
    data_width_8 = 1'b0;
    u_host_bus_model.xfer(1'b0, 1'b0, 8'h80, rv);
    u_host_bus_model.xfer(1'b0, 1'b0, 8'h00, rv);
    check(instr_code_q, 8'h80);
    u_host_bus_model.xfer(1'b1, 1'b1, 8'h00, rv);
    check(rv, 8'h40);
    u_host_bus_model.xfer(1'b1, 1'b1, 8'h00, rv);
    check(rv, 8'h10);
    #1 data_width_8 = 1'b1;
    addr_decrement = 1'b1;
    u_host_bus_model.xfer(1'b0, 1'b0, 8'h81, rv);
    u_host_bus_model.xfer(1'b1, 1'b1, 8'h00, rv);
    check(rv, 8'h42);
    u_host_bus_model.xfer(1'b1, 1'b1, 8'h00, rv);
    check(rv, 8'h41);
    u_host_bus_model.xfer(1'b0, 1'b1, 8'h00, rv);
    check(rv, 8'h7f);
    #1 ram_hold = 1'b1;
    for (int k = 0; k < 9; k++)
      u_host_bus_model.xfer(1'b1, 1'b0, 8'h50, rv);
    check({7'h00, host_ready_q}, 8'h00);
    #1 ram_hold = 1'b0;
    wait_ready();
    #1 link_select_pin = 1'b0;
    u_host_bus_model.frame(16'h0083, rv);
    check(instr_code_q, 8'h83);
    u_host_bus_model.xfer(1'b0, 1'b0, 8'h90, rv);
    check(instr_code_q, 8'h83);
    u_host_bus_model.frame(16'h0100, rv);
    check(rv, 8'h03);
    u_host_bus_model.frame(16'h0040, rv);
    u_host_bus_model.frame(16'h0300, rv);
    check(rv, 8'h1f);
    #1 rst = 1'b1;
    @(posedge ref_clk);
    check(instr_code_q, 8'h00);
    #1 rst = 1'b0;
    repeat (21) @(posedge ref_clk);
    #1 check({7'h00, host_ready_q}, 8'h00);
    @(posedge ref_clk);
    #1 check({7'h00, host_ready_q}, 8'h01);
    u_host_bus_model.frame(16'h0100, rv);
    check(rv, 8'h00);
    complete_run();
  end
endmodule // tb_top
bind vfd_host_interface hostif_checker #(.RESET_WAIT_CYC(RESET_WAIT_CYC)) u_hostif_checker (
  .ref_clk(ref_clk), .rst(rst), .link_select_pin(link_select_pin), .bus_style_select(bus_style_select),
  .data_width_8(data_width_8), .cs_n(cs_n), .register_select(register_select), .e_rd(e_rd), .rw_wr(rw_wr),
  .parallel_data_lines_out_q(parallel_data_lines_out_q), .parallel_data_lines_oe_q(parallel_data_lines_oe_q),
  .instr_strobe_q(instr_strobe_q), .host_ready_q(host_ready_q));
`default_nettype wire
